// *** include/platform_map_pkg.sv ***
`default_nettype none
package platform_map_pkg;
   localparam int ADDR_W = 56;
   localparam int DOFS_W = 52;
   localparam int GB_W = 22;
   localparam int NUM_PERIPH = 18;
   localparam int NUM_DRAM_WIN = 7;
   localparam int NUM_SPI_SRC = 48;
   localparam int NUM_SPI_LINE = 176;
   localparam int NUM_PPI_SRC = 11;
   localparam int NUM_PPI_LINE = 16;
   localparam int NUM_CORES = 8;
   localparam int SPI_ID_BASE = 32;
   localparam int PPI_ID_BASE = 16;
   localparam int TRACK_GRAN = 8;

   localparam logic [ADDR_W-1:0] SWAP_SPAN = 56'h00_0001_0000_0000;
   localparam logic [ADDR_W-1:0] HALF_4G = 56'h00_0000_8000_0000;
   localparam logic [63:0] FILL_WORD = 64'hcfdf_dfdf_dfdf_dfcf;

   typedef enum logic [1:0] {
      ROUTE_PERIPH = 2'b00,
      ROUTE_PCIE = 2'b01,
      ROUTE_DRAM = 2'b11,
      ROUTE_ERROR = 2'b10
   } route_kind_e;

   localparam logic [4:0] REG_PHYS_CPU_IF = 5'h02;
   localparam logic [4:0] REG_VIRT_CPU_IF = 5'h04;
   localparam logic [4:0] REG_RNG = 5'h0c;
   localparam logic [4:0] REG_NV_COUNTER = 5'h0d;
   localparam logic [4:0] REG_ROOT_KEY = 5'h0e;

   localparam logic [ADDR_W-1:0] PERIPH_BASE [NUM_PERIPH] = '{
      56'h00_0000_2b0a_0000, 56'h00_0000_2b40_0000, 56'h00_0000_2c00_0000,
      56'h00_0000_2c01_0000, 56'h00_0000_2c02_f000, 56'h00_0000_2c09_0000,
      56'h00_0000_2e00_0000, 56'h00_0000_2f00_0000, 56'h00_0000_2f02_0000,
      56'h00_0000_2f10_0000, 56'h00_0000_4000_0000, 56'h00_0000_5000_0000,
      56'h00_0000_7fe6_0000, 56'h00_0000_7fe7_0000, 56'h00_0000_7fe8_0000,
      56'h00_0000_7fef_0000, 56'h00_0000_7ff6_0000, 56'h00_0040_0000_0000};
   localparam logic [ADDR_W-1:0] PERIPH_SIZE [NUM_PERIPH] = '{
      56'h1_0000, 56'h10_0000, 56'h2000, 56'h1000, 56'h2000, 56'h1_0000,
      56'h1_0000, 56'h1_0000, 56'h2_0000, 56'h10_0000, 56'h1000_0000,
      56'h1000_0000, 56'h1000, 56'h1000, 56'h1000, 56'h1_0000, 56'h1_0000,
      56'h40_0000_0000};
   localparam logic [NUM_PERIPH-1:0] PERIPH_SECURE = 18'h0_7000;
   localparam logic [NUM_PERIPH-1:0] PERIPH_PCIE = 18'h2_0c02;

   localparam logic [ADDR_W-1:0] DRAM_BASE [NUM_DRAM_WIN] = '{
      56'h00_0000_8000_0000, 56'h00_0008_8000_0000, 56'h00_0088_0000_0000,
      56'h00_0880_0000_0000, 56'h00_8800_0000_0000, 56'h08_8000_0000_0000,
      56'h88_0000_0000_0000};
   localparam logic [ADDR_W-1:0] DRAM_SIZE [NUM_DRAM_WIN] = '{
      56'h00_0000_8000_0000, 56'h00_0007_8000_0000, 56'h00_0078_0000_0000,
      56'h00_0700_0000_0000, 56'h00_7800_0000_0000, 56'h07_8000_0000_0000,
      56'h08_0000_0000_0000};
   localparam logic [ADDR_W-1:0] DRAM_START [NUM_DRAM_WIN] = '{
      56'h00_0000_0000_0000, 56'h00_0000_8000_0000, 56'h00_0008_0000_0000,
      56'h00_0080_0000_0000, 56'h00_0800_0000_0000, 56'h00_8000_0000_0000,
      56'h08_0000_0000_0000};

   localparam logic [7:0] SPI_OFFSET [NUM_SPI_SRC] = '{
      8'd0, 8'd2, 8'd3, 8'd4, 8'd5, 8'd6, 8'd7, 8'd8, 8'd9, 8'd10, 8'd11, 8'd12,
      8'd13, 8'd14, 8'd15, 8'd24, 8'd25, 8'd26, 8'd27, 8'd28, 8'd42, 8'd43, 8'd44,
      8'd48, 8'd60, 8'd61, 8'd62, 8'd63, 8'd64, 8'd65, 8'd66, 8'd67, 8'd71, 8'd72,
      8'd73, 8'd74, 8'd75, 8'd76, 8'd77, 8'd78, 8'd79, 8'd85, 8'd107, 8'd168,
      8'd169, 8'd170, 8'd171, 8'd175};
   localparam int SRC_CARD_IF_A = 8;
   localparam int SRC_COUNTER_SECURE_PHYS = 16;
   localparam int SRC_XLATE_COMBINED = 32;
   localparam int SRC_XLATE_EVENTQ = 35;
   localparam logic [7:0] XLATE_FIRST = 8'd71;
   localparam logic [7:0] XLATE_LAST = 8'd79;
   localparam logic [7:0] PCIE_FIRST = 8'd168;
   localparam logic [7:0] PCIE_LAST = 8'd175;

   localparam logic [3:0] PPI_OFFSET [NUM_PPI_SRC] = '{
      4'd3, 4'd4, 4'd6, 4'd7, 4'd8, 4'd9, 4'd10, 4'd11, 4'd12, 4'd13, 4'd14};
   localparam int PPI_SEC_HYP_VTIMER = 0;
   localparam int PPI_VIF_MAINT = 5;
   localparam int PPI_NS_PHYS_TIMER = 10;
endpackage : platform_map_pkg
`default_nettype wire

// *** hdl/irq_line_router.sv ***
`timescale 1ns/1ps
`default_nettype none
module irq_line_router (
   input wire logic clock, // System clock
   input wire logic rst_n, // Sync reset
   input wire logic pcie_variant, // PCIe-capable platform
   input wire logic [platform_map_pkg::NUM_SPI_SRC-1:0] periph_irq, // Shared sources
   input wire logic [platform_map_pkg::NUM_CORES-1:0][platform_map_pkg::NUM_PPI_SRC-1:0] core_ppi_irq, // Private
   output logic [platform_map_pkg::NUM_SPI_LINE-1:0] spi_line, // Line n is ID n+32
   output logic [platform_map_pkg::NUM_CORES-1:0][platform_map_pkg::NUM_PPI_LINE-1:0] ppi_line // Line n is ID n+16
);
   typedef struct packed {
      logic [platform_map_pkg::NUM_SPI_LINE-1:0] spi;
      logic [platform_map_pkg::NUM_CORES-1:0][platform_map_pkg::NUM_PPI_LINE-1:0] ppi;
   } irq_state_s;

   irq_state_s state_q;
   irq_state_s state_d;

   function automatic logic pcie_only_line(input logic [7:0] off);
      return (off >= platform_map_pkg::XLATE_FIRST && off <= platform_map_pkg::XLATE_LAST) ||
             (off >= platform_map_pkg::PCIE_FIRST && off <= platform_map_pkg::PCIE_LAST);
   endfunction : pcie_only_line

   always_comb
   begin
      state_d = '0;
      for (int i = 0; i < platform_map_pkg::NUM_SPI_SRC; i++)
      begin
         // Offset n lands on ID n+32; PCIe lines gated per variant
         state_d.spi[platform_map_pkg::SPI_OFFSET[i]] = periph_irq[i] &
            (pcie_variant | ~pcie_only_line(platform_map_pkg::SPI_OFFSET[i]));
      end
      for (int c = 0; c < platform_map_pkg::NUM_CORES; c++)
      begin
         for (int k = 0; k < platform_map_pkg::NUM_PPI_SRC; k++)
         begin
            state_d.ppi[c][platform_map_pkg::PPI_OFFSET[k]] = core_ppi_irq[c][k];
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         state_q <= '0;
      else
         state_q <= state_d;
   end

   assign spi_line = state_q.spi;
   assign ppi_line = state_q.ppi;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_spi_first_id: assert property (periph_irq[0] |=> spi_line[0])
      else $error("First shared source not on line 0");
   a_pcie_lines_gated: assert property (!pcie_variant |=> spi_line[79:71] == '0 && spi_line[175:168] == '0)
      else $error("PCIe-only line active in plain variant");
   a_xlate_combined: assert property (pcie_variant && periph_irq[platform_map_pkg::SRC_XLATE_COMBINED]
      |=> spi_line[71])
      else $error("Combined translation irq not on offset 71");
   a_xlate_eventq: assert property (pcie_variant && periph_irq[platform_map_pkg::SRC_XLATE_EVENTQ]
      |=> spi_line[74])
      else $error("Event queue irq not on offset 74");
   a_counter_secure: assert property (1'b1
      |=> spi_line[25] == $past(periph_irq[platform_map_pkg::SRC_COUNTER_SECURE_PHYS]))
      else $error("Secure counter irq not on offset 25");
   a_ns_phys_timer: assert property (core_ppi_irq[0][platform_map_pkg::PPI_NS_PHYS_TIMER] |=> ppi_line[0][14])
      else $error("Timer irq not on private offset 14");
   a_vif_maint: assert property (core_ppi_irq[7][platform_map_pkg::PPI_VIF_MAINT] |=> ppi_line[7][9])
      else $error("Maintenance irq not on private offset 9");
   a_sec_hyp_vtimer: assert property ($rose(core_ppi_irq[3][platform_map_pkg::PPI_SEC_HYP_VTIMER])
      |=> ppi_line[3][3])
      else $error("Secure hyp vtimer not on private offset 3");
endmodule : irq_line_router
`default_nettype wire

// *** hdl/platform_address_irq_map.sv ***
`timescale 1ns/1ps
`default_nettype none
module platform_address_irq_map (
   input wire logic clock, // 125 MHz system clock
   input wire logic rst_n, // Sync reset
   input wire logic swap_variant, // Low 4GB halves exchanged
   input wire logic pcie_variant, // PCIe-capable platform
   input wire logic secure_check_enable, // Abort non-secure to secure-only
   input wire logic [platform_map_pkg::GB_W-1:0] main_memory_gigabytes, // DRAM size in GB
   input wire logic req_valid, // Request present
   input wire logic [platform_map_pkg::ADDR_W-1:0] req_addr, // Request address
   input wire logic req_secure, // Secure access
   input wire logic req_write, // Write access
   input wire logic [platform_map_pkg::NUM_SPI_SRC-1:0] periph_irq, // Shared irq sources
   input wire logic [platform_map_pkg::NUM_CORES-1:0][platform_map_pkg::NUM_PPI_SRC-1:0] core_ppi_irq, // Private
   output logic resp_valid, // Decode result valid
   output platform_map_pkg::route_kind_e resp_kind, // Routed target class
   output logic [4:0] resp_region, // Peripheral window index
   output logic [platform_map_pkg::DOFS_W-1:0] resp_dram_ofs, // Linear DRAM offset
   output logic resp_error, // Error response
   output logic resp_abort, // Security abort
   output logic resp_fill, // Read sees fill pattern
   output logic [63:0] resp_fill_data, // Fill word
   output logic [platform_map_pkg::NUM_SPI_LINE-1:0] spi_line, // Shared lines
   output logic [platform_map_pkg::NUM_CORES-1:0][platform_map_pkg::NUM_PPI_LINE-1:0] ppi_line // Private lines
);
   typedef struct packed {
      logic valid;
      platform_map_pkg::route_kind_e kind;
      logic [4:0] region;
      logic [platform_map_pkg::DOFS_W-1:0] dram_ofs;
      logic error;
      logic abort;
      logic fill;
      logic [63:0] fill_data;
      logic [platform_map_pkg::TRACK_GRAN-1:0] written;
   } map_state_s;

   map_state_s state_q;
   map_state_s state_d;
   logic [platform_map_pkg::ADDR_W-1:0] eff_addr;
   logic [5:0] periph_hit;
   logic [52:0] dram_hit;
   logic [platform_map_pkg::DOFS_W-1:0] dram_limit;
   logic dram_ok;
   logic tracked;
   logic [2:0] gran;

   ////////////////////////////////////////////////////////////////////////////
   // Peripheral lookup: {hit, index}
   function automatic logic [5:0] periph_find(input logic [platform_map_pkg::ADDR_W-1:0] a,
                                              input logic pcie);
      logic [5:0] r;
      r = '0;
      for (int i = 0; i < platform_map_pkg::NUM_PERIPH; i++)
      begin
         if (a >= platform_map_pkg::PERIPH_BASE[i] &&
             (a - platform_map_pkg::PERIPH_BASE[i]) < platform_map_pkg::PERIPH_SIZE[i] &&
             (pcie || !platform_map_pkg::PERIPH_PCIE[i]))
            r = {1'b1, 5'(i)};
      end
      return r;
   endfunction : periph_find

   // DRAM lookup: {hit, linear offset}
   function automatic logic [52:0] dram_find(input logic [platform_map_pkg::ADDR_W-1:0] a);
      logic [52:0] r;
      logic [platform_map_pkg::ADDR_W-1:0] o;
      r = '0;
      o = '0;
      for (int j = 0; j < platform_map_pkg::NUM_DRAM_WIN; j++)
      begin
         if (a >= platform_map_pkg::DRAM_BASE[j] &&
             (a - platform_map_pkg::DRAM_BASE[j]) < platform_map_pkg::DRAM_SIZE[j])
         begin
            o = a - platform_map_pkg::DRAM_BASE[j] + platform_map_pkg::DRAM_START[j];
            r = {1'b1, o[platform_map_pkg::DOFS_W-1:0]};
         end
      end
      return r;
   endfunction : dram_find

   ////////////////////////////////////////////////////////////////////////////
   // Address steering
   always_comb
   begin
      eff_addr = req_addr;
      if (swap_variant && req_addr < platform_map_pkg::SWAP_SPAN)
         eff_addr = req_addr ^ platform_map_pkg::HALF_4G;
      periph_hit = periph_find(eff_addr, pcie_variant);
      dram_hit = dram_find(eff_addr);
      // Windows chain by offset except a gap between window 3 and window 4, so size N fills them in order
      dram_limit = {main_memory_gigabytes, 30'h0};
      dram_ok = dram_hit[52] && dram_hit[51:0] < dram_limit;
      tracked = dram_hit[51:34] == '0;
      gran = dram_hit[33:31];

      state_d = state_q;
      state_d.valid = req_valid;
      state_d.kind = platform_map_pkg::ROUTE_ERROR;
      state_d.region = '0;
      state_d.dram_ofs = '0;
      state_d.error = 1'b0;
      state_d.abort = 1'b0;
      state_d.fill = 1'b0;
      state_d.fill_data = platform_map_pkg::FILL_WORD;
      if (req_valid)
      begin
         if (periph_hit[5])
         begin
            state_d.kind = platform_map_pkg::PERIPH_PCIE[periph_hit[4:0]] ?
               platform_map_pkg::ROUTE_PCIE : platform_map_pkg::ROUTE_PERIPH;
            state_d.region = periph_hit[4:0];
            state_d.abort = platform_map_pkg::PERIPH_SECURE[periph_hit[4:0]] &&
                            secure_check_enable && !req_secure;
         end
         else if (dram_ok)
         begin
            state_d.kind = platform_map_pkg::ROUTE_DRAM;
            state_d.dram_ofs = dram_hit[51:0];
            if (req_write && tracked)
               state_d.written[gran] = 1'b1;
            else if (!req_write)
               state_d.fill = tracked && !state_q.written[gran];
         end
         else
         begin
            state_d.error = 1'b1;
         end
      end
   end

   always_ff @(posedge clock)
   begin
      if (!rst_n)
         state_q <= '0;
      else
         state_q <= state_d;
   end

   assign resp_valid = state_q.valid;
   assign resp_kind = state_q.kind;
   assign resp_region = state_q.region;
   assign resp_dram_ofs = state_q.dram_ofs;
   assign resp_error = state_q.error;
   assign resp_abort = state_q.abort;
   assign resp_fill = state_q.fill;
   assign resp_fill_data = state_q.fill_data;

   ////////////////////////////////////////////////////////////////////////////
   irq_line_router u_irq (
      .clock(clock),
      .rst_n(rst_n),
      .pcie_variant(pcie_variant),
      .periph_irq(periph_irq),
      .core_ppi_irq(core_ppi_irq),
      .spi_line(spi_line),
      .ppi_line(ppi_line)
   );

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);

   a_swap_moves_rng: assert property (req_valid && swap_variant &&
      req_addr == (platform_map_pkg::PERIPH_BASE[12] ^ platform_map_pkg::HALF_4G)
      |=> resp_kind == platform_map_pkg::ROUTE_PERIPH && resp_region == platform_map_pkg::REG_RNG)
      else $error("Swapped address did not reach random source");
   a_dram_within_size: assert property (resp_valid && resp_kind == platform_map_pkg::ROUTE_DRAM
      |-> resp_dram_ofs < {$past(main_memory_gigabytes), 30'h0} && !resp_error)
      else $error("DRAM offset beyond configured size");
   a_dram_four_gb: assert property (req_valid && !swap_variant && main_memory_gigabytes == 22'd4 &&
      req_addr == platform_map_pkg::DRAM_BASE[1]
      |=> resp_kind == platform_map_pkg::ROUTE_DRAM && resp_dram_ofs == 52'h8000_0000)
      else $error("Second window base not at 2GB offset");
   a_dram_eight_gb: assert property (req_valid && !swap_variant && main_memory_gigabytes == 22'd8 &&
      req_addr == 56'h00_0009_ffff_fff8
      |=> resp_kind == platform_map_pkg::ROUTE_DRAM && resp_dram_ofs == 52'h1_ffff_fff8)
      else $error("Top of 8GB not mapped contiguously");
   a_fill_pattern: assert property (resp_fill |-> resp_kind == platform_map_pkg::ROUTE_DRAM &&
      resp_fill_data == platform_map_pkg::FILL_WORD)
      else $error("Fill word wrong or outside DRAM");
   a_fresh_read_fill: assert property ($rose(rst_n) && !req_valid ##1 req_valid && !req_write && !swap_variant &&
      req_addr == platform_map_pkg::DRAM_BASE[0] && main_memory_gigabytes != '0 |=> resp_fill)
      else $error("Unwritten read did not see fill");
   a_rng_secure_only: assert property (req_valid && !swap_variant && secure_check_enable && !req_secure &&
      req_addr[55:12] == platform_map_pkg::PERIPH_BASE[12][55:12] |=> resp_abort && !resp_error)
      else $error("Non-secure random source access not aborted");
   a_secure_passes: assert property (req_valid && req_secure |=> !resp_abort)
      else $error("Secure access aborted");
   a_virt_cpu_window: assert property (req_valid && !swap_variant && !req_secure &&
      req_addr == platform_map_pkg::PERIPH_BASE[4] + 56'h1ffc
      |=> resp_region == platform_map_pkg::REG_VIRT_CPU_IF && !resp_abort && !resp_error)
      else $error("Virtual CPU window end not decoded");
   a_unmapped_error: assert property (req_valid && req_addr == 56'h00_0000_3000_0000 && !swap_variant
      |=> resp_error && resp_kind == platform_map_pkg::ROUTE_ERROR)
      else $error("Unmapped address completed silently");
   a_beyond_size: assert property (req_valid && !swap_variant && main_memory_gigabytes == 22'd4 &&
      req_addr == 56'h00_0009_0000_0000 |=> resp_error)
      else $error("Access beyond DRAM size not refused");

   c_dram_write: cover property (req_valid && req_write ##1 resp_kind == platform_map_pkg::ROUTE_DRAM);
   c_secure_abort: cover property (resp_abort);
   c_swap_access: cover property (req_valid && swap_variant ##1 resp_valid && !resp_error);
   c_fill_read: cover property (resp_fill);
endmodule : platform_address_irq_map
`default_nettype wire

// *** tb/bus_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
   input wire logic clock, // System clock
   output logic req_valid, // Request strobe
   output logic [platform_map_pkg::ADDR_W-1:0] req_addr, // Request address
   output logic req_secure, // Secure access
   output logic req_write // Write access
);
   initial
   begin
      req_valid = 1'b0;
      req_addr = '1;
      req_secure = 1'b0;
      req_write = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////////
   // One request per edge, changed only just after the edge
   task automatic issue(input logic [platform_map_pkg::ADDR_W-1:0] a, input logic s, input logic w);
      @(posedge clock);
      req_valid <= 1'b1;
      req_addr <= a;
      req_secure <= s;
      req_write <= w;
   endtask : issue
   // Idle bus shows the inverse of the last address
   task automatic release_bus();
      @(posedge clock);
      req_valid <= 1'b0;
      req_addr <= ~req_addr;
      req_write <= ~req_write;
   endtask : release_bus
endmodule : bus_master_model
`default_nettype wire

// *** tb/platform_address_irq_map_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module platform_address_irq_map_test;
   typedef struct packed {
      platform_map_pkg::route_kind_e kind;
      logic [4:0] region;
      logic [platform_map_pkg::DOFS_W-1:0] ofs;
      logic err;
      logic abt;
      logic fill;
   } decode_s;
   localparam decode_s bad_addr = {platform_map_pkg::ROUTE_ERROR, 5'h00, 52'h0, 3'b100};
   localparam decode_s denied = {platform_map_pkg::ROUTE_ERROR, 5'h00, 52'h0, 3'b010};
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   logic swap_variant = 1'b0;
   logic pcie_variant = 1'b1;
   logic secure_check_enable = 1'b1;
   logic [platform_map_pkg::GB_W-1:0] main_memory_gigabytes = 22'h4;
   logic [platform_map_pkg::NUM_SPI_SRC-1:0] periph_irq = '0;
   logic [platform_map_pkg::NUM_CORES-1:0][platform_map_pkg::NUM_PPI_SRC-1:0] core_ppi_irq = '0;
   logic [platform_map_pkg::NUM_CORES-1:0][platform_map_pkg::NUM_PPI_SRC-1:0] pv;
   logic [platform_map_pkg::NUM_CORES-1:0][platform_map_pkg::NUM_PPI_LINE-1:0] ppi_line, ep;
   logic [platform_map_pkg::NUM_SPI_LINE-1:0] spi_line, es;
   logic req_valid, req_secure, req_write, resp_valid, resp_error, resp_abort, resp_fill;
   logic [platform_map_pkg::ADDR_W-1:0] req_addr, a;
   platform_map_pkg::route_kind_e resp_kind;
   logic [4:0] resp_region;
   logic [platform_map_pkg::DOFS_W-1:0] resp_dram_ofs;
   logic [63:0] resp_fill_data;
   decode_s expq[$];
   decode_s want, seen;
   int fail_count = 0;
   int compares = 0;
   int i, k, c, p, r;

   always #4 clock = ~clock;

   bus_master_model u_bus_master_model (.clock(clock), .req_valid(req_valid), .req_addr(req_addr),
      .req_secure(req_secure), .req_write(req_write));

   platform_address_irq_map u_platform_address_irq_map (.clock(clock), .rst_n(rst_n),
      .swap_variant(swap_variant), .pcie_variant(pcie_variant), .secure_check_enable(secure_check_enable),
      .main_memory_gigabytes(main_memory_gigabytes), .req_valid(req_valid), .req_addr(req_addr),
      .req_secure(req_secure), .req_write(req_write), .periph_irq(periph_irq), .core_ppi_irq(core_ppi_irq),
      .resp_valid(resp_valid), .resp_kind(resp_kind), .resp_region(resp_region), .resp_dram_ofs(resp_dram_ofs),
      .resp_error(resp_error), .resp_abort(resp_abort), .resp_fill(resp_fill), .resp_fill_data(resp_fill_data),
      .spi_line(spi_line), .ppi_line(ppi_line));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [175:0] exp, input logic [175:0] got);
      compares++;
      if (got !== exp)
      begin
         fail_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   function automatic decode_s dram(input logic [55:0] o, input logic f);
      return {platform_map_pkg::ROUTE_DRAM, 5'h00, o[platform_map_pkg::DOFS_W-1:0], 2'b00, f};
   endfunction : dram

   function automatic decode_s dev(input platform_map_pkg::route_kind_e kd, input int n);
      return {kd, n[4:0], 52'h0, 3'b000};
   endfunction : dev

   task automatic req(input logic [55:0] ad, input logic s, input logic w, input decode_s e);
      expq.push_back(e);
      u_bus_master_model.issue(ad, s, w);
   endtask : req

   // Idle the bus and apply the next configuration, then let answers drain
   task automatic mode(input string done, input int gb, input logic sw, input logic pc, input logic se);
      u_bus_master_model.release_bus();
      main_memory_gigabytes <= gb[21:0];
      swap_variant <= sw;
      pcie_variant <= pc;
      secure_check_enable <= se;
      repeat (2) @(posedge clock);
      $display("Test %s ended", done);
   endtask : mode

   task automatic final_report();
      $display("Comparisons %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : final_report
   ////////////////////////////////////////////////////////////////////////////////
   // Answers are taken off the queue in order
   always @(posedge clock)
   begin
      if (resp_valid === 1'b1)
      begin
         seen = {resp_kind, resp_region, resp_dram_ofs, resp_error, resp_abort, resp_fill};
         if (expq.size() == 0)
            check("unexpected answer", 176'h0, 176'h1);
         else
         begin
            want = expq.pop_front();
            if (want.abt)
               check("abort", 176'({want.err, want.abt}), 176'({resp_error, resp_abort}));
            else
               check("decode", 176'(want), 176'(seen));
            if (want.fill)
               check("fill word", 176'(platform_map_pkg::FILL_WORD), 176'(resp_fill_data));
         end
      end
   end

   initial
   begin
      repeat (5000) @(posedge clock);
      fail_count++;
      final_report();
   end

   initial
   begin
      r = $urandom(40306);
      repeat (20) @(posedge clock);
      rst_n <= 1'b1;
      #1;
      check("valid after reset", 176'h0, 176'(resp_valid));
      mode("reset", 4, 1'b0, 1'b1, 1'b1);
      req(56'h00_0000_8000_0000, 1'b0, 1'b0, dram(56'h0, 1'b1));
      req(56'h00_0008_8000_0000, 1'b1, 1'b0, dram(56'h8000_0000, 1'b1));
      req(56'h00_0008_ffff_fff8, 1'b0, 1'b0, dram(56'hffff_fff8, 1'b1));
      req(56'h00_0009_0000_0000, 1'b0, 1'b0, bad_addr);
      mode("four gigabytes", 8, 1'b0, 1'b1, 1'b1);
      req(56'h00_0009_0000_0000, 1'b0, 1'b0, dram(56'h1_0000_0000, 1'b1));
      req(56'h00_0009_ffff_fff8, 1'b0, 1'b0, dram(56'h1_ffff_fff8, 1'b1));
      req(56'h00_000a_0000_0000, 1'b0, 1'b0, bad_addr);
      mode("eight gigabytes", 4000000, 1'b0, 1'b1, 1'b1);
      for (i = 0; i < platform_map_pkg::NUM_DRAM_WIN; i++)
      begin
         req(platform_map_pkg::DRAM_BASE[i], 1'b0, 1'b0, dram(platform_map_pkg::DRAM_START[i], i < 2));
         a = platform_map_pkg::DRAM_SIZE[i] - 56'h8;
         req(platform_map_pkg::DRAM_BASE[i] + a, 1'b1, 1'b0,
            (i == 6) ? bad_addr : dram(platform_map_pkg::DRAM_START[i] + a, i == 0));
      end
      mode("contiguous windows", 4, 1'b0, 1'b1, 1'b1);
      req(56'h00_0000_8000_0100, 1'b0, 1'b1, dram(56'h100, 1'b0));
      req(56'h00_0000_8000_0000, 1'b0, 1'b0, dram(56'h0, 1'b0));
      for (i = 0; i < 20; i++)
      begin
         a = {24'h0, $urandom} & 56'h7fff_fff8;
         req(56'h8000_0000 + a, 1'($urandom), 1'b0, dram(a, 1'b0));
      end
      mode("written memory", 4, 1'b0, 1'b1, 1'b1);
      // Mid-run reset clears the written flags
      rst_n <= 1'b0;
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      req(56'h8000_0000, 1'b0, 1'b0, dram(56'h0, 1'b1));
      req(56'h8000_0000, 1'b1, 1'b1, dram(56'h0, 1'b0));
      for (i = 12; i < 15; i++)
      begin
         req(platform_map_pkg::PERIPH_BASE[i], 1'b0, 1'b0, denied);
         req(platform_map_pkg::PERIPH_BASE[i] + 56'hff8, 1'b1, 1'b1, dev(platform_map_pkg::ROUTE_PERIPH, i));
         req(platform_map_pkg::PERIPH_BASE[i] + 56'h1000, 1'b1, 1'b0, bad_addr);
      end
      req(56'h2c02_f000, 1'b1, 1'b0, dev(platform_map_pkg::ROUTE_PERIPH, 4));
      req(56'h2c03_0ffc, 1'b0, 1'b1, dev(platform_map_pkg::ROUTE_PERIPH, 4));
      req(56'h2c03_1000, 1'b0, 1'b0, bad_addr);
      req(56'h3000_0000, 1'b0, 1'b0, bad_addr);
      mode("secure windows", 4, 1'b0, 1'b1, 1'b0);
      req(56'h7fe6_0000, 1'b0, 1'b0, dev(platform_map_pkg::ROUTE_PERIPH, 12));
      mode("check disabled", 4, 1'b1, 1'b1, 1'b1);
      req(56'hffe6_0000, 1'b1, 1'b0, dev(platform_map_pkg::ROUTE_PERIPH, 12));
      req(56'h7fe6_0000, 1'b0, 1'b0, dram(56'h7fe6_0000, 1'b0));
      req(56'h8000_0000, 1'b0, 1'b0, bad_addr);
      mode("swapped map", 4, 1'b0, 1'b0, 1'b1);
      req(56'h4000_0000, 1'b0, 1'b0, bad_addr);
      req(56'h40_0000_0000, 1'b0, 1'b0, bad_addr);
      mode("no pcie", 4, 1'b0, 1'b1, 1'b1);
      req(56'h4000_0000, 1'b0, 1'b0, dev(platform_map_pkg::ROUTE_PCIE, 10));
      req(56'h40_0000_0000, 1'b1, 1'b1, dev(platform_map_pkg::ROUTE_PCIE, 17));
      mode("pcie windows", 4, 1'b0, 1'b1, 1'b1);
      for (p = 0; p < 2; p++)
      begin
         for (i = 0; i < platform_map_pkg::NUM_SPI_SRC; i++)
         begin
            es = '0;
            k = platform_map_pkg::SPI_OFFSET[i];
            if (p == 1 || !((k >= 71 && k <= 79) || k >= 168))
               es[k] = 1'b1;
            @(posedge clock);
            pcie_variant <= p[0];
            periph_irq <= 48'h1 << i;
            repeat (2) @(posedge clock);
            #1;
            check("shared line", es, spi_line);
         end
      end
      for (k = 0; k < platform_map_pkg::NUM_PPI_SRC; k++)
      begin
         c = $urandom % platform_map_pkg::NUM_CORES;
         pv = '0;
         ep = '0;
         // All cores but one random core; watched cores always on
         for (p = 0; p < platform_map_pkg::NUM_CORES; p++)
         begin
            pv[p][k] = p != c || p == 0 || p == 3 || p == 7;
            ep[p][platform_map_pkg::PPI_OFFSET[k]] = pv[p][k];
         end
         @(posedge clock);
         core_ppi_irq <= pv;
         repeat (2) @(posedge clock);
         #1;
         check("private line", 176'(ep), 176'(ppi_line));
      end
      $display("Test interrupt lines ended");
      check("answers left", 176'h0, 176'(expq.size()));
      final_report();
   end
endmodule : platform_address_irq_map_test
`default_nettype wire
